// ==== include/pllcs_defs.svh ====
// Constants for the PLL configuration and status block: offsets, fields, resets.
// Assumes an APB slave with 32-bit data, one register per aligned word.
// Function
// - Multiplier and reference divider writes need guard clear and PLL source selected.
// - Accepted multiplier or reference divider write clears settled and oscillator-qualified status.
// - Settled VCO frequency is two times reference times multiplier plus one.
// - Reference is oscillator over divider plus one, else internal 1 MHz.
// - Internal reference fixes filter to 1-2 MHz range; range field ignored.
// - Output divider writes need only PLL source selected, guard ignored.
// - PLL output is VCO over divider plus one settled, VCO over four otherwise.
// - With PLL selected, bus clock is half the PLL output.
// - Output divider steps gradually, reaching target within 32 bus clocks.
// - Tick flag bit 7 set each tick, cleared by writing one.
// - Settle-change flag bit 4 set on any settled status change.
// - Read-only settled status bit 3 shows VCO within tolerance.
// - Oscillator-change flag bit 1 set on qualified status change.
// - Read-only qualified status bit 0, cleared entering full stop.
// - Qualified status zero forces the PLL source select bit to one.
`ifndef PLLCS_DEFS_SVH
`define PLLCS_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PLLCS_IDX_MULT 8'h04
`define PLLCS_IDX_REFERENCE_DIVIDER 8'h05
`define PLLCS_IDX_OUTDIV 8'h06
`define PLLCS_IDX_FLAGS 8'h07
`define PLLCS_IDX_IRQEN 8'h08
`define PLLCS_IDX_CTRL 8'h09
`define PLLCS_IDX_DERIVED 8'h0A

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PLLCS_MULT_LSB 0
`define PLLCS_MULT_MSB 5
`define PLLCS_VRANGE_LSB 6
`define PLLCS_VRANGE_MSB 7
`define PLLCS_RDIV_MSB 3
`define PLLCS_RRANGE_LSB 6
`define PLLCS_RRANGE_MSB 7
`define PLLCS_ODIV_MSB 4
`define PLLCS_BIT_TICK 7
`define PLLCS_BIT_SCHG 4
`define PLLCS_BIT_SETTLED 3
`define PLLCS_BIT_OCHG 1
`define PLLCS_BIT_OSCQ 0
`define PLLCS_BIT_GUARD 0
`define PLLCS_BIT_PSEL 1
`define PLLCS_BIT_EXTOSC 2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define PLLCS_RST_MULT 8'h00
`define PLLCS_RST_REFERENCE_DIVIDER 8'h00
`define PLLCS_RST_OUTDIV 5'h00
`define PLLCS_RST_CTRL 3'h2
`define PLLCS_UNSETTLED_DIV 5'h03
`define PLLCS_RAMP_BUS_CYCLES 32
`define PLLCS_RAMP_STEPS 5'h1F
`define PLLCS_FIXED_FILTER 2'h0
`define PLLCS_ACCESS_DELAY_NS 4
`define PLLCS_CLK_PERIOD_NS 4

`endif

// ==== include/pllcs_pkg.sv ====
// Types for the PLL configuration and status block.
// Assumes the constants header is compiled alongside.
package pllcs_pkg;

    // Registered status of the analog loop and oscillator
    typedef struct packed {
        logic settled;
        logic osc_qualified;
    } pllcs_status_type;

    // Change and tick flags, laid out as in the flags register
    typedef struct packed {
        logic tick;
        logic settle_chg;
        logic osc_chg;
    } pllcs_flags_type;

    // Bus slave phases
    typedef enum logic [0:0] {
        PLLCS_IDLE,
        PLLCS_ACCESS
    } pllcs_bus_state_type;

endpackage : pllcs_pkg

// ==== hw/pllcs_top.sv ====
// PLL configuration, frequency relations, gradual divider ramp and event flags.
// Assumes analog loop, oscillator and tick counter report status as async levels/pulses.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "pllcs_defs.svh"

module pllcs_top #(
    parameter int MULT_W = 6,
    parameter int RDIV_W = 4,
    parameter int ODIV_W = 5
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Analog status and mode inputs (asynchronous)
    input wire logic settled_in,
    input wire logic osc_running_in,
    input wire logic full_stop_in,
    input wire logic periodic_tick_in,
    input wire logic bus_enable_in,
    // Configuration to the analog loop, and the interrupt request
    output logic [MULT_W-1:0] loop_multiplier_out,
    output logic [1:0] vco_range_out,
    output logic [RDIV_W-1:0] reference_divider_out,
    output logic [1:0] filter_range_out,
    output logic ext_osc_enable_out,
    output logic [ODIV_W-1:0] output_divider_out,
    output logic pll_source_select_out,
    output logic loop_restart_out,
    output logic irq_out
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic tick_prev_reg;
    logic bus_en_prev_reg;
    wire logic settled_s = sync2_reg[0];
    wire logic osc_run_s = sync2_reg[1];
    wire logic full_stop_s = sync2_reg[2];
    wire logic tick_s = sync2_reg[3];
    wire logic bus_en_s = sync2_reg[4];
    wire logic tick_rise = tick_s & ~tick_prev_reg;
    // Bus clock is half of the PLL output; the analog side marks its rising edges
    wire logic bus_tick = bus_en_s & ~bus_en_prev_reg;

    // First stage feeds only the second stage
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            sync1_reg <= 5'h0_0;
            sync2_reg <= 5'h0_0;
            tick_prev_reg <= 1'b0;
            bus_en_prev_reg <= 1'b0;
        end else begin
            // Bit order matches the named taps of the second stage
            sync1_reg <= {bus_enable_in, periodic_tick_in, full_stop_in, osc_running_in, settled_in};
            sync2_reg <= sync1_reg;
            tick_prev_reg <= tick_s;
            bus_en_prev_reg <= bus_en_s;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    pllcs_pkg::pllcs_bus_state_type bus_state_reg;
    pllcs_pkg::pllcs_status_type status_reg;
    pllcs_pkg::pllcs_flags_type flags_reg;
    pllcs_pkg::pllcs_flags_type irqen_reg;
    logic [7:0] mult_reg;
    logic [7:0] reference_divider_reg;
    logic [ODIV_W-1:0] odiv_target_reg;
    logic [ODIV_W-1:0] odiv_cur_reg;
    logic [2:0] ctrl_reg;
    logic settled_prev_reg;
    logic oscq_prev_reg;

    // Address decode; only word-aligned offsets in the map respond
    wire logic [7:0] idx = {2'b00, paddr_in[7:2]};
    wire logic aligned = (paddr_in[1:0] == 2'b00) && (paddr_in[11:8] == 4'h0);
    wire logic hit_mult = aligned && (idx == `PLLCS_IDX_MULT);
    wire logic hit_reference_divider = aligned && (idx == `PLLCS_IDX_REFERENCE_DIVIDER);
    wire logic hit_outdiv = aligned && (idx == `PLLCS_IDX_OUTDIV);
    wire logic hit_flags = aligned && (idx == `PLLCS_IDX_FLAGS);
    wire logic hit_irqen = aligned && (idx == `PLLCS_IDX_IRQEN);
    wire logic hit_ctrl = aligned && (idx == `PLLCS_IDX_CTRL);
    wire logic hit_derived = aligned && (idx == `PLLCS_IDX_DERIVED);
    wire logic hit_any = hit_mult | hit_reference_divider | hit_outdiv | hit_flags | hit_irqen | hit_ctrl | hit_derived;
    // Access phase lasts until pready is sampled, so it must not depend on the phase flop
    wire logic access = psel_in & penable_in;
    wire logic wr = access & pwrite_in & hit_any;

    wire logic guard = ctrl_reg[`PLLCS_BIT_GUARD];
    wire logic psel_bit = ctrl_reg[`PLLCS_BIT_PSEL];
    wire logic ext_osc = ctrl_reg[`PLLCS_BIT_EXTOSC];
    // Loop settings change only with guard clear and the PLL sourcing the clock
    wire logic loop_wr_ok = ~guard & psel_bit;
    wire logic mult_wr = wr & hit_mult & loop_wr_ok;
    wire logic reference_divider_wr = wr & hit_reference_divider & loop_wr_ok;
    wire logic loop_changed = mult_wr | reference_divider_wr;
    // Output divider ignores the guard
    wire logic odiv_wr = wr & hit_outdiv & psel_bit;

    // Status: hold cleared from a loop change until the analog side drops its own level
    logic restart_hold_reg;
    wire logic settled_next = settled_s & ~loop_changed & ~restart_hold_reg;
    wire logic oscq_next = osc_run_s & ~full_stop_s & ~loop_changed & ~restart_hold_reg;

    // Flags: hardware set wins over software clear
    wire logic [2:0] w1c = (wr & hit_flags) ?
        {pwdata_in[`PLLCS_BIT_TICK], pwdata_in[`PLLCS_BIT_SCHG], pwdata_in[`PLLCS_BIT_OCHG]} : 3'h0;
    wire logic set_tick = tick_rise;
    wire logic set_schg = status_reg.settled ^ settled_prev_reg;
    wire logic set_ochg = status_reg.osc_qualified ^ oscq_prev_reg;
    wire logic [2:0] flags_next = ({flags_reg.tick, flags_reg.settle_chg, flags_reg.osc_chg} & ~w1c)
        | {set_tick, set_schg, set_ochg};

    // Effective output divider: fixed divide-by-four while unsettled
    wire logic [ODIV_W-1:0] odiv_goal = status_reg.settled ? odiv_target_reg : ODIV_W'(`PLLCS_UNSETTLED_DIV);
    // One step per bus clock; a 5-bit span never needs more than 31 steps
    wire logic [ODIV_W-1:0] odiv_step = (odiv_cur_reg < odiv_goal) ? odiv_cur_reg + ODIV_W'(1) :
        (odiv_cur_reg > odiv_goal) ? odiv_cur_reg - ODIV_W'(1) : odiv_cur_reg;

    // Read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_mult) rdata[7:0] = mult_reg;
        if (hit_reference_divider) rdata[7:0] = reference_divider_reg;
        if (hit_outdiv) rdata[ODIV_W-1:0] = odiv_target_reg;
        if (hit_flags) begin
            rdata[`PLLCS_BIT_TICK] = flags_reg.tick;
            rdata[`PLLCS_BIT_SCHG] = flags_reg.settle_chg;
            rdata[`PLLCS_BIT_SETTLED] = status_reg.settled;
            rdata[`PLLCS_BIT_OCHG] = flags_reg.osc_chg;
            rdata[`PLLCS_BIT_OSCQ] = status_reg.osc_qualified;
        end
        if (hit_irqen) begin
            rdata[`PLLCS_BIT_TICK] = irqen_reg.tick;
            rdata[`PLLCS_BIT_SCHG] = irqen_reg.settle_chg;
            rdata[`PLLCS_BIT_OCHG] = irqen_reg.osc_chg;
        end
        if (hit_ctrl) rdata[2:0] = ctrl_reg;
        if (hit_derived) rdata[ODIV_W-1:0] = odiv_cur_reg;
    end

    // ----------------------------------------------------------------
    // APB slave: access phase with one wait state
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            bus_state_reg <= pllcs_pkg::PLLCS_IDLE;
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            if (psel_in && !penable_in) begin
                bus_state_reg <= pllcs_pkg::PLLCS_ACCESS;
            end else if (access) begin
                bus_state_reg <= pllcs_pkg::PLLCS_IDLE;
            end
            // Answer registered so pready comes from a flop; master sees it one cycle into access
            if (psel_in && penable_in && !pready_out && bus_state_reg == pllcs_pkg::PLLCS_ACCESS) begin
                pready_out <= 1'b1;
                pslverr_out <= ~hit_any;
                prdata_out <= rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Writes land at the completing edge (pready high); access held by the master until then
    wire logic commit = wr & pready_out;
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            mult_reg <= `PLLCS_RST_MULT;
            reference_divider_reg <= `PLLCS_RST_REFERENCE_DIVIDER;
            odiv_target_reg <= ODIV_W'(`PLLCS_RST_OUTDIV);
            irqen_reg <= 3'h0;
            ctrl_reg <= `PLLCS_RST_CTRL;
        end else begin
            if (mult_wr && commit) mult_reg <= pwdata_in[7:0];
            if (reference_divider_wr && commit) reference_divider_reg <= pwdata_in[7:0];
            if (odiv_wr && commit) odiv_target_reg <= pwdata_in[ODIV_W-1:0];
            if (wr && commit && hit_irqen) begin
                irqen_reg <= {pwdata_in[`PLLCS_BIT_TICK], pwdata_in[`PLLCS_BIT_SCHG], pwdata_in[`PLLCS_BIT_OCHG]};
            end
            if (wr && commit && hit_ctrl) ctrl_reg <= pwdata_in[2:0];
            // Without a qualified oscillator the PLL must source the clock
            if (!status_reg.osc_qualified) ctrl_reg[`PLLCS_BIT_PSEL] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Status, flags, ramp and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            status_reg <= 2'h0;
            settled_prev_reg <= 1'b0;
            oscq_prev_reg <= 1'b0;
            restart_hold_reg <= 1'b0;
            flags_reg <= 3'h0;
            odiv_cur_reg <= ODIV_W'(`PLLCS_UNSETTLED_DIV);
            irq_out <= 1'b0;
        end else begin
            status_reg.settled <= settled_next & ~(loop_changed & commit) | (settled_next & ~loop_changed);
            status_reg.osc_qualified <= oscq_next;
            settled_prev_reg <= status_reg.settled;
            oscq_prev_reg <= status_reg.osc_qualified;
            // Hold status low after a loop change until the analog side reports unsettled
            if (loop_changed && commit) restart_hold_reg <= 1'b1;
            else if (!settled_s) restart_hold_reg <= 1'b0;
            flags_reg <= commit ? flags_next : (flags_next | {flags_reg.tick, flags_reg.settle_chg, flags_reg.osc_chg});
            if (bus_tick) odiv_cur_reg <= odiv_step;
            irq_out <= |({flags_reg.tick, flags_reg.settle_chg, flags_reg.osc_chg}
                & {irqen_reg.tick, irqen_reg.settle_chg, irqen_reg.osc_chg});
        end
    end

    // Outputs to the analog loop, all from flops
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            loop_multiplier_out <= '0;
            vco_range_out <= 2'h0;
            reference_divider_out <= '0;
            filter_range_out <= `PLLCS_FIXED_FILTER;
            ext_osc_enable_out <= 1'b0;
            output_divider_out <= ODIV_W'(`PLLCS_UNSETTLED_DIV);
            pll_source_select_out <= 1'b1;
            loop_restart_out <= 1'b0;
        end else begin
            // VCO = 2 x reference x (multiplier + 1) is realised by the analog loop
            loop_multiplier_out <= mult_reg[MULT_W-1:0];
            vco_range_out <= mult_reg[`PLLCS_VRANGE_MSB:`PLLCS_VRANGE_LSB];
            // Reference divider only matters with the external oscillator enabled
            reference_divider_out <= ext_osc ? reference_divider_reg[RDIV_W-1:0] : '0;
            // Internal reference pins the filter; the range field stays writable
            filter_range_out <= ext_osc ? reference_divider_reg[`PLLCS_RRANGE_MSB:`PLLCS_RRANGE_LSB]
                : `PLLCS_FIXED_FILTER;
            ext_osc_enable_out <= ext_osc;
            output_divider_out <= odiv_cur_reg;
            pll_source_select_out <= psel_bit;
            loop_restart_out <= loop_changed & commit;
        end
    end

endmodule : pllcs_top

// ==== sim/pllcs_properties.sv ====
// Port-level checks for the PLL configuration and status block.
// Assumes binding onto pllcs_top; sees only its ports, one clock domain.
`timescale 1ns/1ps

module pllcs_properties #(
    parameter int MULT_W = 6,
    parameter int RDIV_W = 4,
    parameter int ODIV_W = 5
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic osc_running_in,
    input wire logic [MULT_W-1:0] loop_multiplier_out,
    input wire logic [RDIV_W-1:0] reference_divider_out,
    input wire logic [1:0] filter_range_out,
    input wire logic ext_osc_enable_out,
    input wire logic [ODIV_W-1:0] output_divider_out,
    input wire logic pll_source_select_out,
    input wire logic loop_restart_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    // Completing write to the multiplier or reference divider word
    wire logic loop_wr = psel_in & penable_in & pwrite_in & pready_out & (paddr_in inside {12'h010, 12'h014});

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_ready_wait;
        $rose(penable_in) && psel_in |=> pready_out;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready late");
    property p_ready_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_err_ready;
        pslverr_out |-> pready_out;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_mult_cause;
        $changed(loop_multiplier_out) |-> $past(loop_wr) || $past(loop_wr, 2);
    endproperty
    a_mult_cause: assert property (p_mult_cause) else $error("multiplier changed without write");
    property p_restart_cause;
        loop_restart_out |-> $past(loop_wr) || $past(loop_wr, 2);
    endproperty
    a_restart_cause: assert property (p_restart_cause) else $error("restart without write");
    property p_int_ref;
        !ext_osc_enable_out [*2] |-> filter_range_out == 2'h0 && reference_divider_out == '0;
    endproperty
    a_int_ref: assert property (p_int_ref) else $error("filter not fixed on internal ref");
    property p_psel_forced;
        !osc_running_in [*6] |-> pll_source_select_out;
    endproperty
    a_psel_forced: assert property (p_psel_forced) else $error("pll select not forced");
    property p_ramp_step;
        $changed(output_divider_out) |-> output_divider_out == ODIV_W'($past(output_divider_out) + 1)
            || output_divider_out == ODIV_W'($past(output_divider_out) - 1);
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("divider jumped");

    c_loop_wr: cover property (loop_restart_out);
    c_ramp: cover property ($changed(output_divider_out));
    c_err: cover property (pslverr_out);
endmodule : pllcs_properties

// ==== sim/pllcs_tb_top.sv ====
// Self-checking bench for the PLL configuration block, driven over APB.
// Assumes one wait state on APB and about three cycles of status sync.
`timescale 1ns/1ps
`include "pllcs_defs.svh"
`define CHK(nm, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end end

module pllcs_tb_top;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic settled_in = 1'b0;
    logic osc_running_in = 1'b0;
    logic full_stop_in = 1'b0;
    logic periodic_tick_in = 1'b0;
    logic [1:0] bus_div = 2'h0;
    logic bus_enable_in;
    logic [31:0] prdata_out, rd_q;
    logic pready_out, pslverr_out, rd_e, ext_osc_enable_out, pll_source_select_out, loop_restart_out, irq_out;
    logic [5:0] loop_multiplier_out;
    logic [1:0] vco_range_out, filter_range_out;
    logic [3:0] reference_divider_out;
    logic [4:0] output_divider_out;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;

    pllcs_top dut_u (.mclk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .settled_in, .osc_running_in, .full_stop_in,
        .periodic_tick_in, .bus_enable_in, .loop_multiplier_out, .vco_range_out, .reference_divider_out,
        .filter_range_out, .ext_osc_enable_out, .output_divider_out, .pll_source_select_out,
        .loop_restart_out, .irq_out);

    // Clock, bus clock at a quarter rate, and a hang guard
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end
    assign bus_enable_in = bus_div[1];
    always @(posedge mclk_in) begin
        bus_div <= bus_div + 2'h1;
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // One transfer; two extra edges at the end let registered effects land
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= {2'b00, idx, 2'b00};
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        if (n == 50) err_total++;
        rd_q = prdata_out;
        rd_e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
    endtask : apb

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        apb(1'b0, idx, 32'h0000_0000);
        `CHK(nm, exp, rd_q)
    endtask : rdc

    task automatic wt(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : wt

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_guard();
        `CHK("psel out", 1'b1, pll_source_select_out)
        `CHK("reset div", 5'h03, output_divider_out)
        rdc(`PLLCS_IDX_CTRL, 32'h0000_0002, "ctrl");
        apb(1'b1, `PLLCS_IDX_CTRL, 32'h0000_0003);
        apb(1'b1, `PLLCS_IDX_MULT, 32'h0000_0045);
        rdc(`PLLCS_IDX_MULT, 32'h0000_0000, "guarded mult");
        apb(1'b1, `PLLCS_IDX_REFERENCE_DIVIDER, 32'h0000_0045);
        rdc(`PLLCS_IDX_REFERENCE_DIVIDER, 32'h0000_0000, "guarded reference_divider");
        apb(1'b1, `PLLCS_IDX_OUTDIV, 32'h0000_000A);
        rdc(`PLLCS_IDX_OUTDIV, 32'h0000_000A, "outdiv");
        apb(1'b1, `PLLCS_IDX_CTRL, 32'h0000_0002);
        apb(1'b1, `PLLCS_IDX_MULT, 32'h0000_0045);
        rdc(`PLLCS_IDX_MULT, 32'h0000_0045, "mult");
        `CHK("mult out", 6'h05, loop_multiplier_out)
        `CHK("vco range", 2'h1, vco_range_out)
    endtask : test_guard

    task automatic test_psel();
        osc_running_in <= 1'b1;
        wt(6);
        rdc(`PLLCS_IDX_FLAGS, 32'h0000_0003, "qualified");
        apb(1'b1, `PLLCS_IDX_CTRL, 32'h0000_0000);
        apb(1'b1, `PLLCS_IDX_OUTDIV, 32'h0000_0007);
        rdc(`PLLCS_IDX_OUTDIV, 32'h0000_000A, "outdiv held");
        apb(1'b1, `PLLCS_IDX_MULT, 32'h0000_0010);
        rdc(`PLLCS_IDX_MULT, 32'h0000_0045, "mult held");
        osc_running_in <= 1'b0;
        wt(6);
        `CHK("psel forced", 1'b1, pll_source_select_out)
        rdc(`PLLCS_IDX_FLAGS, 32'h0000_0002, "osc change");
        apb(1'b1, `PLLCS_IDX_CTRL, 32'h0000_0002);
    endtask : test_psel

    task automatic test_flags();
        apb(1'b1, `PLLCS_IDX_FLAGS, 32'h0000_00FF);
        apb(1'b1, `PLLCS_IDX_IRQEN, 32'h0000_0092);
        `CHK("irq idle", 1'b0, irq_out)
        periodic_tick_in <= 1'b1;
        wt(3);
        periodic_tick_in <= 1'b0;
        settled_in <= 1'b1;
        wt(6);
        rdc(`PLLCS_IDX_FLAGS, 32'h0000_0098, "tick settle");
        `CHK("irq on", 1'b1, irq_out)
        apb(1'b1, `PLLCS_IDX_FLAGS, 32'h0000_0008);
        rdc(`PLLCS_IDX_FLAGS, 32'h0000_0098, "zero write");
        apb(1'b1, `PLLCS_IDX_FLAGS, 32'h0000_0080);
        rdc(`PLLCS_IDX_FLAGS, 32'h0000_0018, "tick clear");
        apb(1'b1, `PLLCS_IDX_IRQEN, 32'h0000_0002);
        `CHK("irq masked", 1'b0, irq_out)
        apb(1'b1, `PLLCS_IDX_IRQEN, 32'h0000_0010);
        `CHK("irq settle", 1'b1, irq_out)
        apb(1'b1, `PLLCS_IDX_FLAGS, 32'h0000_0010);
        `CHK("irq clear", 1'b0, irq_out)
    endtask : test_flags

    task automatic test_loop();
        apb(1'b1, `PLLCS_IDX_OUTDIV, 32'h0000_001F);
        wt(130);
        `CHK("ramped div", 5'h1F, output_divider_out)
        apb(1'b1, `PLLCS_IDX_MULT, 32'h0000_0046);
        wt(6);
        rdc(`PLLCS_IDX_FLAGS, 32'h0000_0010, "loop write");
        wt(130);
        `CHK("unsettled div", 5'h03, output_divider_out)
        settled_in <= 1'b0;
        osc_running_in <= 1'b1;
        wt(6);
        apb(1'b1, `PLLCS_IDX_FLAGS, 32'h0000_00FF);
        rdc(`PLLCS_IDX_FLAGS, 32'h0000_0001, "qualified up");
        full_stop_in <= 1'b1;
        wt(6);
        rdc(`PLLCS_IDX_FLAGS, 32'h0000_0002, "full stop");
    endtask : test_loop

    task automatic test_ext();
        apb(1'b1, `PLLCS_IDX_REFERENCE_DIVIDER, 32'h0000_00C5);
        `CHK("ref div off", 4'h0, reference_divider_out)
        `CHK("filter off", 2'h0, filter_range_out)
        apb(1'b1, `PLLCS_IDX_CTRL, 32'h0000_0006);
        `CHK("ref div on", 4'h5, reference_divider_out)
        `CHK("filter on", 2'h3, filter_range_out)
        apb(1'b0, 8'h3F, 32'h0000_0000);
        `CHK("unmapped", 1'b1, rd_e)
    endtask : test_ext

    // Main sequence
    initial begin
        repeat (20) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        @(posedge mclk_in);
        test_guard();
        test_psel();
        test_flags();
        test_loop();
        test_ext();
        results();
    end
endmodule : pllcs_tb_top

bind pllcs_top pllcs_properties #(.MULT_W(MULT_W), .RDIV_W(RDIV_W), .ODIV_W(ODIV_W)) chk_u (
    .mclk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pready_out, .pslverr_out,
    .osc_running_in, .loop_multiplier_out, .reference_divider_out, .filter_range_out, .ext_osc_enable_out,
    .output_divider_out, .pll_source_select_out, .loop_restart_out);
